// [include/rcs_consts.svh]
// Constants of the reader command sequencer
// Notes on behaviour
// (RULE1) Power-down pin high for 10 us starts the internal reset.
// (RULE2) Reset runs power-on phase then start-up phase before ready.
// (RULE3) Host writes a command code; the sequencer runs that command.
// (RULE4) All arguments and data travel through the FIFO only.
// (RULE5) Transmit frames: optional start symbol, data, optional end symbol.
// (RULE6) Commands with fixed arguments wait until all are in the FIFO.
// (RULE7) Command start never flushes the FIFO; load data first.
// (RULE8) A new command code interrupts the running command.
// (RULE9) Code 00h idles and cancels the running command.
// (RULE10) Code 01h samples I/Q, compares limits, flags detection, maybe standby.
// (RULE11) Code 02h moves six key bytes to key buffer; aborts if fewer.
// (RULE12) Code 03h authenticates with 60h/61h, block and four serial bytes.
// (RULE13) Code 05h enables receive; code 06h transmits FIFO contents.
// (RULE14) Code 07h transmits, then switches to receive automatically.
// (RULE15) Code 08h writes one byte to memory, key area only.
// (RULE16) Code 09h writes up to 64 bytes as one key-area page.
// (RULE17) Code 0Ah copies a length of memory bytes into the FIFO.
// (RULE18) Code 0Ch copies memory bytes from sector 2 into registers.
// (RULE19) Code 0Dh loads receive and transmit protocol presets into registers.
// (RULE20) Code 0Eh loads a stored key; 0Fh stores a key from FIFO.
// (RULE21) Code 1Ch fills the FIFO with random bytes until full.
// (RULE22) Code 1Fh soft-resets the whole device.
// (RULE23) Transmit ends when the FIFO empties or another command arrives.
// (RULE24) Memory reads past 1FFFh wrap to 0000h.
// (RULE25) On completion or abort the command code returns to idle.
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH
`define RCS_CLK_MHZ 10
`define RCS_PD_HOLD_NS 10000
`define RCS_POR_NS 2000
`define RCS_STARTUP_NS 15000
`define RCS_HOLD_CYC ((`RCS_PD_HOLD_NS * `RCS_CLK_MHZ + 999) / 1000)
`define RCS_POR_CYC ((`RCS_POR_NS * `RCS_CLK_MHZ + 999) / 1000)
`define RCS_START_CYC ((`RCS_STARTUP_NS * `RCS_CLK_MHZ + 999) / 1000)
`define RCS_CMD_IDLE 8'h00
`define RCS_CMD_DETECT 8'h01
`define RCS_CMD_KEYF 8'h02
`define RCS_CMD_AUTH 8'h03
`define RCS_CMD_RECV 8'h05
`define RCS_CMD_SEND 8'h06
`define RCS_CMD_XCV 8'h07
`define RCS_CMD_NWB 8'h08
`define RCS_CMD_NWP 8'h09
`define RCS_CMD_NRD 8'h0A
`define RCS_CMD_NREG 8'h0C
`define RCS_CMD_PROT 8'h0D
`define RCS_CMD_KEYN 8'h0E
`define RCS_CMD_KEYS 8'h0F
`define RCS_CMD_RNG 8'h1C
`define RCS_CMD_SRST 8'h1F
`define RCS_NARG_KEYF 3'h6
`define RCS_NARG_AUTH 3'h6
`define RCS_NARG_NWB 3'h3
`define RCS_NARG_NWP 3'h1
`define RCS_NARG_NRD 3'h3
`define RCS_NARG_NREG 3'h4
`define RCS_NARG_PROT 3'h2
`define RCS_NARG_KEYN 3'h1
`define RCS_NARG_KEYS 3'h7
`define RCS_AUTH_A 8'h60
`define RCS_AUTH_B 8'h61
`define RCS_KEY_LEN 9'h006
`define RCS_PAGE_LEN 9'h040
`define RCS_RD_MAX 9'h100
`define RCS_CNT_INF 9'h1FF
`define RCS_NVM_TOP 13'h1FFF
`define RCS_KEY_LO 13'h0C00
`define RCS_KEY_HI 13'h17FF
`define RCS_KEY_NUM 8'h80
`define RCS_SECT2_LO 13'h0100
`define RCS_SECT2_HI 13'h01FF
`define RCS_PROTO_NUM 8'h04
`define RCS_PRESET_LEN 9'h008
`define RCS_RX_PRESET 13'h0040
`define RCS_TX_PRESET 13'h0060
`define RCS_RX_REG_BASE 8'h48
`define RCS_TX_REG_BASE 8'h28
`define RCS_FIFO_EMPTY 10'h000
`define RCS_TXK_DATA 2'h0
`define RCS_TXK_SOF 2'h1
`define RCS_TXK_EOF 2'h2
`define RCS_FC_SOF 0
`define RCS_FC_EOF 1
`endif

// [include/rcs_pkg.sv]
// Types of the reader command sequencer
package rcs_pkg;
	typedef enum logic [3:0] {ST_IDLE, ST_ARGS, ST_EXEC, ST_DETECT, ST_AUTH,
		ST_RECV, ST_SOF, ST_FETCH, ST_PUT, ST_END, ST_EOF} rcs_state_type;
	typedef enum logic [1:0] {SRC_ARG, SRC_NVM, SRC_FIFO, SRC_RNG} rcs_src_type;
	typedef enum logic [2:0] {DST_FIFO, DST_REG, DST_KEY, DST_NVM, DST_TX}
		rcs_dst_type;
	typedef enum logic [1:0] {PH_RUN, PH_DOWN, PH_POR, PH_START} rcs_phase_type;
endpackage

// [rtl/rcs_nvm_mem.sv]
// Non-volatile byte store, 8K x 8, registered read data
`timescale 1ns/100ps
module rcs_nvm_mem
	import rcs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic clk_en,
	input wire logic we,
	input wire logic [12:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem_r [0:8191];

	always_ff @(posedge ref_clk)
	begin
		if (clk_en)
		begin
			if (we)
				mem_r[addr] <= wdata;
			rdata <= mem_r[addr];
		end
	end
endmodule

// [rtl/rcs_reset_seq.sv]
// Power-down pin filter and two-phase internal start-up
`timescale 1ns/100ps
`include "rcs_consts.svh"
module rcs_reset_seq
	import rcs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic power_down_pin,
	input wire logic soft_rst,
	output logic core_rst,
	output logic dev_ready
);
	logic pd_meta_r;
	logic pd_sync_r;
	logic [7:0] tmr_r;
	logic [7:0] tmr_nxt;
	rcs_phase_type ph_r;
	rcs_phase_type ph_nxt;

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			pd_meta_r <= 1'b0;
			pd_sync_r <= 1'b0;
		end
		else if (clk_en)
		begin
			pd_meta_r <= power_down_pin;
			pd_sync_r <= pd_meta_r;
		end
	end

	always_comb
	begin
		ph_nxt = ph_r;
		tmr_nxt = tmr_r + 8'h01;
		unique case (ph_r)
		PH_RUN:
			if (soft_rst)
			begin
				ph_nxt = PH_POR;
				tmr_nxt = 8'h00;
			end
			else if (!pd_sync_r)
				tmr_nxt = 8'h00;
			else if (tmr_r == 8'(`RCS_HOLD_CYC - 1)) // [RULE1]
				ph_nxt = PH_DOWN;
		PH_DOWN:
		begin
			tmr_nxt = 8'h00;
			if (!pd_sync_r)
				ph_nxt = PH_POR;
		end
		PH_POR:
			if (tmr_r == 8'(`RCS_POR_CYC - 1)) // [RULE2]
			begin
				ph_nxt = PH_START;
				tmr_nxt = 8'h00;
			end
		PH_START:
			if (tmr_r == 8'(`RCS_START_CYC - 1)) // [RULE2]
			begin
				ph_nxt = PH_RUN;
				tmr_nxt = 8'h00;
			end
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			ph_r <= PH_POR;
			tmr_r <= 8'h00;
			core_rst <= 1'b1;
			dev_ready <= 1'b0;
		end
		else if (clk_en)
		begin
			ph_r <= ph_nxt;
			tmr_r <= tmr_nxt;
			core_rst <= (ph_nxt != PH_RUN);
			dev_ready <= (ph_nxt == PH_RUN); // [RULE2]
		end
	end

	a_pd_hold_down: assert property (@(posedge ref_clk) disable iff (reset) // [RULE1]
		clk_en && ph_r == PH_RUN && pd_sync_r && !soft_rst
		&& tmr_r == 8'(`RCS_HOLD_CYC - 1) |=> ph_r == PH_DOWN && !dev_ready)
		else $error("reset did not start after power-down hold");
	a_ready_after_start: assert property (@(posedge ref_clk) disable iff (reset) // [RULE2]
		$rose(dev_ready) |-> $past(ph_r) == PH_START)
		else $error("ready raised outside start-up phase");
endmodule

// [rtl/rcs_sequencer.sv]
// Command sequencer of the reader core: dispatch, argument fetch, streams
`timescale 1ns/100ps
`include "rcs_consts.svh"
module rcs_sequencer
	import rcs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic power_down_pin,
	input wire logic cmd_wr,
	input wire logic [7:0] cmd_wr_code,
	output logic [7:0] cmd_code,
	output logic device_ready,
	output logic cmd_abort,
	input wire logic [9:0] fifo_count,
	input wire logic fifo_full,
	input wire logic [7:0] fifo_rd_data,
	output logic fifo_pop,
	output logic fifo_push,
	output logic [7:0] fifo_wr_data,
	input wire logic [1:0] tx_frame_config,
	input wire logic tx_ready,
	output logic tx_valid,
	output logic [1:0] tx_kind,
	output logic [7:0] tx_byte,
	input wire logic rx_done,
	output logic rx_enable,
	input wire logic iq_valid,
	input wire logic [7:0] i_sample,
	input wire logic [7:0] q_sample,
	input wire logic [7:0] i_min,
	input wire logic [7:0] i_max,
	input wire logic [7:0] q_min,
	input wire logic [7:0] q_max,
	input wire logic standby_sel,
	output logic [7:0] i_result,
	output logic [7:0] q_result,
	output logic card_detect_irq,
	output logic standby_req,
	output logic key_wr,
	output logic [2:0] key_idx,
	output logic [7:0] key_byte,
	input wire logic auth_done,
	output logic auth_start,
	output logic auth_key_b,
	output logic [7:0] auth_block,
	output logic [31:0] auth_serial,
	output logic reg_wr,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_data,
	input wire logic [7:0] rng_byte,
	output logic soft_reset
);
	rcs_state_type st_r;
	rcs_src_type src_r;
	rcs_dst_type dst_r;
	logic [7:0] cmd_r;
	logic [7:0] arg_r [0:6];
	logic [2:0] ai_r;
	logic [2:0] need_r;
	logic [12:0] addr_r;
	logic [8:0] cnt_r;
	logic [7:0] raddr_r;
	logic inf_r;
	logic phase2_r;
	logic core_rst;
	logic rst_all;
	logic start;
	logic arg_take;
	logic src_live;
	logic put_go;
	logic mem_we;
	logic eof_ok;
	logic out_lim;
	logic [7:0] mem_rdata;
	logic [7:0] put_byte;

	function automatic logic [2:0] args_needed(input logic [7:0] code);
		case (code)
		`RCS_CMD_KEYF: args_needed = `RCS_NARG_KEYF;
		`RCS_CMD_AUTH: args_needed = `RCS_NARG_AUTH;
		`RCS_CMD_NWB: args_needed = `RCS_NARG_NWB;
		`RCS_CMD_NWP: args_needed = `RCS_NARG_NWP;
		`RCS_CMD_NRD: args_needed = `RCS_NARG_NRD;
		`RCS_CMD_NREG: args_needed = `RCS_NARG_NREG;
		`RCS_CMD_PROT: args_needed = `RCS_NARG_PROT;
		`RCS_CMD_KEYN: args_needed = `RCS_NARG_KEYN;
		`RCS_CMD_KEYS: args_needed = `RCS_NARG_KEYS;
		default: args_needed = 3'h0;
		endcase
	endfunction

	function automatic logic in_key_area(input logic [12:0] a);
		in_key_area = (a >= `RCS_KEY_LO) && (a <= `RCS_KEY_HI);
	endfunction

	function automatic logic [12:0] key_addr(input logic [7:0] idx);
		key_addr = `RCS_KEY_LO + 13'(idx) * 13'(`RCS_KEY_LEN);
	endfunction

	rcs_reset_seq u_reset_seq (
		.ref_clk(ref_clk),
		.reset(reset),
		.clk_en(clk_en),
		.power_down_pin(power_down_pin),
		.soft_rst(soft_reset),
		.core_rst(core_rst),
		.dev_ready(device_ready)
	);

	rcs_nvm_mem u_nvm (
		.ref_clk(ref_clk),
		.clk_en(clk_en),
		.we(mem_we),
		.addr(addr_r),
		.wdata(put_byte),
		.rdata(mem_rdata)
	);

	assign rst_all = reset || core_rst;
	assign start = cmd_wr && device_ready; // [RULE3]
	assign cmd_code = cmd_r;
	assign arg_take = st_r == ST_ARGS && !fifo_pop && ai_r != need_r
		&& fifo_count >= 10'(need_r - ai_r); // [RULE6]
	assign src_live = !(src_r == SRC_FIFO && fifo_count == `RCS_FIFO_EMPTY);
	assign put_go = st_r == ST_PUT && src_live
		&& !(dst_r == DST_FIFO && fifo_full) && !(dst_r == DST_TX && !tx_ready);
	assign mem_we = clk_en && !start && put_go && dst_r == DST_NVM;
	assign eof_ok = !tx_frame_config[`RCS_FC_EOF] || tx_ready;
	assign out_lim = i_sample < i_min || i_sample > i_max
		|| q_sample < q_min || q_sample > q_max;

	always_comb
	begin
		unique case (src_r)
		SRC_ARG: put_byte = arg_r[ai_r];
		SRC_NVM: put_byte = mem_rdata;
		SRC_FIFO: put_byte = fifo_rd_data;
		SRC_RNG: put_byte = rng_byte;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Arguments are data only, so no reset is needed here
	always_ff @(posedge ref_clk)
	begin
		if (clk_en && !start && arg_take)
			arg_r[ai_r] <= fifo_rd_data; // [RULE4]
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk)
	begin
		if (rst_all)
		begin
			st_r <= ST_IDLE;
			cmd_r <= `RCS_CMD_IDLE;
			src_r <= SRC_ARG;
			dst_r <= DST_FIFO;
			ai_r <= 3'h0;
			need_r <= 3'h0;
			addr_r <= 13'h0000;
			cnt_r <= 9'h000;
			raddr_r <= 8'h00;
			inf_r <= 1'b0;
			phase2_r <= 1'b0;
			cmd_abort <= 1'b0;
			fifo_pop <= 1'b0;
			fifo_push <= 1'b0;
			fifo_wr_data <= 8'h00;
			tx_valid <= 1'b0;
			tx_kind <= `RCS_TXK_DATA;
			tx_byte <= 8'h00;
			rx_enable <= 1'b0;
			key_wr <= 1'b0;
			key_idx <= 3'h0;
			key_byte <= 8'h00;
			auth_start <= 1'b0;
			auth_key_b <= 1'b0;
			auth_block <= 8'h00;
			auth_serial <= 32'h00000000;
			reg_wr <= 1'b0;
			reg_addr <= 8'h00;
			reg_data <= 8'h00;
			soft_reset <= 1'b0;
		end
		else if (clk_en)
		begin
			cmd_abort <= 1'b0;
			fifo_pop <= 1'b0;
			fifo_push <= 1'b0;
			tx_valid <= 1'b0;
			key_wr <= 1'b0;
			auth_start <= 1'b0;
			reg_wr <= 1'b0;
			soft_reset <= 1'b0;
			if (start)
			begin
				// Any write cancels the running command; FIFO is kept
				cmd_r <= cmd_wr_code; // [RULE8] [RULE7]
				rx_enable <= 1'b0;
				ai_r <= 3'h0;
				need_r <= args_needed(cmd_wr_code);
				phase2_r <= 1'b0;
				st_r <= ST_ARGS;
				if (cmd_wr_code == `RCS_CMD_IDLE)
					st_r <= ST_IDLE; // [RULE9]
				else if (cmd_wr_code == `RCS_CMD_SRST)
				begin
					soft_reset <= 1'b1; // [RULE22]
					st_r <= ST_IDLE;
				end
				else if (cmd_wr_code == `RCS_CMD_KEYF
					&& fifo_count < 10'(`RCS_KEY_LEN))
				begin
					cmd_abort <= 1'b1; // [RULE11]
					st_r <= ST_IDLE;
				end
			end
			else
			begin
				unique case (st_r)
				ST_IDLE:
				begin
					cmd_r <= `RCS_CMD_IDLE; // [RULE25]
					rx_enable <= 1'b0;
				end
				ST_ARGS:
					if (arg_take)
					begin
						fifo_pop <= 1'b1; // [RULE4]
						ai_r <= ai_r + 3'h1;
					end
					else if (!fifo_pop && ai_r == need_r)
						st_r <= ST_EXEC;
				ST_EXEC:
				begin
					ai_r <= 3'h0;
					inf_r <= 1'b0;
					st_r <= ST_FETCH;
					unique case (cmd_r)
					`RCS_CMD_DETECT: st_r <= ST_DETECT;
					`RCS_CMD_KEYF:
					begin
						src_r <= SRC_ARG; // [RULE11]
						dst_r <= DST_KEY;
						cnt_r <= `RCS_KEY_LEN;
					end
					`RCS_CMD_AUTH:
						if (arg_r[0] == `RCS_AUTH_A || arg_r[0] == `RCS_AUTH_B)
						begin
							auth_start <= 1'b1; // [RULE12]
							auth_key_b <= arg_r[0][0];
							auth_block <= arg_r[1];
							auth_serial <= {arg_r[5], arg_r[4], arg_r[3], arg_r[2]};
							st_r <= ST_AUTH;
						end
						else
						begin
							cmd_abort <= 1'b1;
							st_r <= ST_IDLE;
						end
					`RCS_CMD_RECV:
					begin
						rx_enable <= 1'b1; // [RULE13]
						st_r <= ST_RECV;
					end
					`RCS_CMD_SEND, `RCS_CMD_XCV:
					begin
						src_r <= SRC_FIFO; // [RULE13]
						dst_r <= DST_TX;
						inf_r <= 1'b1;
						// Stale count of an earlier command would end the frame
						cnt_r <= `RCS_CNT_INF;
						st_r <= ST_SOF;
					end
					`RCS_CMD_NWB:
					begin
						src_r <= SRC_ARG;
						dst_r <= DST_NVM;
						ai_r <= 3'h2;
						addr_r <= {arg_r[1][4:0], arg_r[0]};
						cnt_r <= 9'h001;
						if (arg_r[1][7:5] != 3'h0
							|| !in_key_area({arg_r[1][4:0], arg_r[0]}))
						begin
							cmd_abort <= 1'b1; // [RULE15]
							st_r <= ST_IDLE;
						end
					end
					`RCS_CMD_NWP:
					begin
						src_r <= SRC_FIFO;
						dst_r <= DST_NVM;
						addr_r <= {arg_r[0][6:0], 6'h00};
						cnt_r <= `RCS_PAGE_LEN;
						if (arg_r[0][7] || !in_key_area({arg_r[0][6:0], 6'h00}))
						begin
							cmd_abort <= 1'b1; // [RULE16]
							st_r <= ST_IDLE;
						end
					end
					`RCS_CMD_NRD:
					begin
						src_r <= SRC_NVM; // [RULE17]
						dst_r <= DST_FIFO;
						addr_r <= {arg_r[1][4:0], arg_r[0]};
						cnt_r <= (arg_r[2] == 8'h00) ? `RCS_RD_MAX : {1'b0, arg_r[2]};
						if (arg_r[1][7:5] != 3'h0
							|| !in_key_area({arg_r[1][4:0], arg_r[0]}))
						begin
							cmd_abort <= 1'b1;
							st_r <= ST_IDLE;
						end
					end
					`RCS_CMD_NREG:
					begin
						src_r <= SRC_NVM; // [RULE18]
						dst_r <= DST_REG;
						addr_r <= {arg_r[1][4:0], arg_r[0]};
						raddr_r <= arg_r[2];
						cnt_r <= {1'b0, arg_r[3]};
						if (arg_r[1][7:5] != 3'h0
							|| {arg_r[1][4:0], arg_r[0]} < `RCS_SECT2_LO
							|| {arg_r[1][4:0], arg_r[0]} > `RCS_SECT2_HI)
						begin
							cmd_abort <= 1'b1;
							st_r <= ST_IDLE;
						end
					end
					`RCS_CMD_PROT:
					begin
						src_r <= SRC_NVM; // [RULE19]
						dst_r <= DST_REG;
						addr_r <= `RCS_RX_PRESET
							+ 13'(arg_r[0]) * 13'(`RCS_PRESET_LEN);
						raddr_r <= `RCS_RX_REG_BASE;
						cnt_r <= `RCS_PRESET_LEN;
						if (arg_r[0] >= `RCS_PROTO_NUM || arg_r[1] >= `RCS_PROTO_NUM)
						begin
							cmd_abort <= 1'b1;
							st_r <= ST_IDLE;
						end
					end
					`RCS_CMD_KEYN, `RCS_CMD_KEYS:
					begin
						src_r <= (cmd_r == `RCS_CMD_KEYN) ? SRC_NVM : SRC_ARG;
						dst_r <= (cmd_r == `RCS_CMD_KEYN) ? DST_KEY : DST_NVM;
						ai_r <= 3'h1;
						addr_r <= key_addr(arg_r[0]); // [RULE20]
						cnt_r <= `RCS_KEY_LEN;
						if (arg_r[0] >= `RCS_KEY_NUM)
						begin
							cmd_abort <= 1'b1;
							st_r <= ST_IDLE;
						end
					end
					`RCS_CMD_RNG:
					begin
						src_r <= SRC_RNG; // [RULE21]
						dst_r <= DST_FIFO;
						inf_r <= 1'b1;
						cnt_r <= `RCS_CNT_INF;
					end
					default: st_r <= ST_IDLE;
					endcase
				end
				ST_DETECT:
					if (iq_valid)
						st_r <= ST_IDLE; // [RULE10]
				ST_AUTH:
					if (auth_done)
						st_r <= ST_IDLE;
				ST_RECV:
					if (rx_done)
						st_r <= ST_IDLE;
				ST_SOF:
					if (!tx_frame_config[`RCS_FC_SOF])
						st_r <= ST_FETCH;
					else if (tx_ready)
					begin
						tx_valid <= 1'b1; // [RULE5]
						tx_kind <= `RCS_TXK_SOF;
						st_r <= ST_FETCH;
					end
				ST_FETCH:
					st_r <= (cnt_r == 9'h000) ? ST_END : ST_PUT;
				ST_PUT:
					if (!src_live)
						st_r <= ST_END; // [RULE23]
					else if (src_r == SRC_RNG && fifo_full)
						st_r <= ST_END; // [RULE21]
					else if (put_go)
					begin
						st_r <= ST_FETCH;
						addr_r <= addr_r + 13'h0001; // [RULE24]
						if (!inf_r)
							cnt_r <= cnt_r - 9'h001;
						if (src_r == SRC_ARG)
							ai_r <= ai_r + 3'h1;
						fifo_pop <= (src_r == SRC_FIFO);
						unique case (dst_r)
						DST_FIFO:
						begin
							fifo_push <= 1'b1;
							fifo_wr_data <= put_byte;
						end
						DST_REG:
						begin
							reg_wr <= 1'b1;
							reg_addr <= raddr_r;
							reg_data <= put_byte;
							raddr_r <= raddr_r + 8'h01;
						end
						DST_KEY:
						begin
							key_wr <= 1'b1;
							key_idx <= 3'(`RCS_KEY_LEN - cnt_r);
							key_byte <= put_byte;
						end
						DST_NVM:
							tx_kind <= `RCS_TXK_DATA;
						DST_TX:
						begin
							tx_valid <= 1'b1; // [RULE5]
							tx_kind <= `RCS_TXK_DATA;
							tx_byte <= put_byte;
						end
						endcase
					end
				ST_END:
					if (cmd_r == `RCS_CMD_SEND || cmd_r == `RCS_CMD_XCV)
						st_r <= ST_EOF;
					else if (cmd_r == `RCS_CMD_PROT && !phase2_r)
					begin
						phase2_r <= 1'b1; // [RULE19]
						addr_r <= `RCS_TX_PRESET
							+ 13'(arg_r[1]) * 13'(`RCS_PRESET_LEN);
						raddr_r <= `RCS_TX_REG_BASE;
						cnt_r <= `RCS_PRESET_LEN;
						st_r <= ST_FETCH;
					end
					else
						st_r <= ST_IDLE;
				ST_EOF:
					if (eof_ok)
					begin
						tx_valid <= tx_frame_config[`RCS_FC_EOF]; // [RULE5]
						tx_kind <= `RCS_TXK_EOF;
						st_r <= ST_IDLE;
						if (cmd_r == `RCS_CMD_XCV)
						begin
							cmd_r <= `RCS_CMD_RECV; // [RULE14]
							rx_enable <= 1'b1;
							st_r <= ST_RECV;
						end
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Detection results; flag is a one-cycle event
	always_ff @(posedge ref_clk)
	begin
		if (rst_all)
		begin
			i_result <= 8'h00;
			q_result <= 8'h00;
			card_detect_irq <= 1'b0;
			standby_req <= 1'b0;
		end
		else if (clk_en)
		begin
			card_detect_irq <= 1'b0;
			if (start)
				standby_req <= 1'b0;
			else if (st_r == ST_DETECT && iq_valid)
			begin
				i_result <= i_sample; // [RULE10]
				q_result <= q_sample;
				card_detect_irq <= out_lim;
				standby_req <= standby_sel;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	a_idle_cancels: assert property (@(posedge ref_clk) disable iff (rst_all) // [RULE9]
		clk_en && start && cmd_wr_code == `RCS_CMD_IDLE
		|=> st_r == ST_IDLE ##1 (cmd_r == `RCS_CMD_IDLE || !clk_en
		|| $past(start)))
		else $error("idle code did not cancel command");
	a_new_cmd_takes: assert property (@(posedge ref_clk) disable iff (rst_all) // [RULE8]
		clk_en && start && st_r != ST_IDLE && cmd_wr_code != `RCS_CMD_SRST
		|=> cmd_r == $past(cmd_wr_code) && !fifo_pop) // [RULE7]
		else $error("running command not replaced");
	a_key_short_abort: assert property (@(posedge ref_clk) disable iff (rst_all) // [RULE11]
		clk_en && start && cmd_wr_code == `RCS_CMD_KEYF
		&& fifo_count < 10'(`RCS_KEY_LEN) |=> cmd_abort && st_r == ST_IDLE)
		else $error("short key load not aborted");
	a_args_wait: assert property (@(posedge ref_clk) disable iff (rst_all) // [RULE6]
		clk_en && !start && st_r == ST_ARGS && ai_r != need_r
		&& fifo_count < 10'(need_r - ai_r) |=> !fifo_pop)
		else $error("argument popped before all present");
	a_abort_to_idle: assert property (@(posedge ref_clk) disable iff (rst_all) // [RULE25]
		cmd_abort && clk_en && !start |=> cmd_r == `RCS_CMD_IDLE)
		else $error("command code not idle after abort");
	a_tx_ends_empty: assert property (@(posedge ref_clk) disable iff (rst_all) // [RULE23]
		clk_en && !start && st_r == ST_PUT && dst_r == DST_TX && !src_live
		|=> st_r == ST_END ##1 (st_r == ST_EOF || !clk_en))
		else $error("transmit did not end on empty FIFO");
	a_nvm_wrap: assert property (@(posedge ref_clk) disable iff (rst_all) // [RULE24]
		clk_en && !start && put_go && addr_r == `RCS_NVM_TOP
		|=> addr_r == 13'h0000)
		else $error("memory address did not wrap");
	a_write_key_area: assert property (@(posedge ref_clk) disable iff (rst_all) // [RULE15]
		mem_we |-> in_key_area(addr_r)) // [RULE16]
		else $error("memory write outside key area");
	a_rx_after_tx: assert property (@(posedge ref_clk) disable iff (rst_all) // [RULE14]
		clk_en && !start && st_r == ST_EOF && eof_ok && cmd_r == `RCS_CMD_XCV
		|=> rx_enable && st_r == ST_RECV)
		else $error("transceive did not switch to receive");
	a_detect_flag: assert property (@(posedge ref_clk) disable iff (rst_all) // [RULE10]
		clk_en && !start && st_r == ST_DETECT && iq_valid
		|=> card_detect_irq == $past(out_lim) && i_result == $past(i_sample))
		else $error("detection result or flag wrong");

	c_key_load: cover property (@(posedge ref_clk) disable iff (rst_all)
		key_wr && key_idx == 3'h5);
	c_transceive: cover property (@(posedge ref_clk) disable iff (rst_all)
		st_r == ST_EOF ##1 st_r == ST_RECV);
	c_random_full: cover property (@(posedge ref_clk) disable iff (rst_all)
		st_r == ST_PUT && src_r == SRC_RNG && fifo_full);
endmodule

// [dv/rcs_fifo_model.sv]
// Host-side byte FIFO model feeding and draining the sequencer
`timescale 1ns/100ps
module rcs_fifo_model
(
	input wire logic ref_clk,
	input wire logic load,
	input wire logic [7:0] load_byte,
	input wire logic fifo_pop,
	input wire logic fifo_push,
	input wire logic [7:0] fifo_wr_data,
	output logic [9:0] fifo_count = 10'h000,
	output logic fifo_full = 1'h0,
	output logic [7:0] fifo_rd_data = 8'h00
);
	logic [7:0] q[$];
	logic [7:0] last = 8'h00;
	// Only path for arguments and data
	always @(posedge ref_clk)
	begin
		if (fifo_pop && q.size() > 0)
			last = q.pop_front();
		if (load)
			q.push_back(load_byte);
		if (fifo_push)
			q.push_back(fifo_wr_data);
		fifo_count <= 10'(q.size());
		fifo_full <= q.size() >= 512;
		// Empty head shows the inverse, never a stale byte
		fifo_rd_data <= q.size() > 0 ? q[0] : ~last;
	end
endmodule

// [dv/tb_rcs_sequencer.sv]
// Self-checking bench of the reader command sequencer
`timescale 1ns/100ps
`include "rcs_consts.svh"
module tb_rcs_sequencer;
	logic ref_clk = 1'h0, reset = 1'h1, clk_en = 1'h1, cmd_wr = 1'h0;
	logic power_down_pin = 1'h0, tx_ready = 1'h1, rx_done = 1'h0;
	logic iq_valid = 1'h0, standby_sel = 1'h0, load = 1'h0;
	logic auth_done = 1'h0;
	logic [1:0] tx_frame_config = 2'h3;
	logic [7:0] cmd_wr_code = 8'h00, load_byte = 8'h00, i_sample = 8'h30;
	logic [7:0] q_sample = 8'h18, i_min = 8'h10, i_max = 8'h20;
	logic [7:0] q_min = 8'h10, q_max = 8'h20, rng_byte = 8'h00;
	logic device_ready, cmd_abort, fifo_pop, fifo_push, fifo_full;
	logic tx_valid, rx_enable, card_detect_irq, standby_req, key_wr;
	logic auth_start, auth_key_b, reg_wr, soft_reset;
	logic [1:0] tx_kind;
	logic [2:0] key_idx;
	logic [7:0] cmd_code, fifo_wr_data, fifo_rd_data, tx_byte, key_byte;
	logic [7:0] i_result, q_result, auth_block, reg_addr, reg_data;
	logic [9:0] fifo_count;
	logic [31:0] auth_serial;
	logic [9:0] txq[$];
	logic [10:0] keyq[$];
	int n_abort = 0, n_irq = 0, cyc = 0, mismatches = 0, check_count = 0;

	rcs_sequencer uut (.*);
	rcs_fifo_model fifo (.*);

	initial
		forever #50 ref_clk = ~ref_clk;

	always @(posedge ref_clk)
	begin
		cyc++;
		if (tx_valid)
			txq.push_back({tx_kind, tx_byte});
		if (key_wr)
			keyq.push_back({key_idx, key_byte});
		n_abort += cmd_abort;
		n_irq += card_detect_irq;
		// Ceiling well above the few thousand cycles the run needs
		if (cyc == 20000)
		begin
			mismatches++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] s, e);
		check_count++;
		if (s !== e)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, e, s);
		end
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic put_cmd(input logic [7:0] c);
		@(posedge ref_clk);
		cmd_wr <= 1'h1;
		cmd_wr_code <= c;
		@(posedge ref_clk);
		cmd_wr <= 1'h0;
	endtask

	// Arguments go in before the command code, except in the 08h wait check of t_nvm
	task automatic fill(input logic [7:0] b, input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge ref_clk);
			load <= 1'h1;
			load_byte <= b + 8'(i);
		end
		@(posedge ref_clk);
		load <= 1'h0;
	endtask

	task automatic wait_idle;
		tick(3);
		for (int i = 0; i < 400 && cmd_code !== 8'h00; i++)
			@(posedge ref_clk);
		check("code back to idle", cmd_code, 0);
	endtask

	task automatic wait_ready;
		for (int i = 0; i < 400 && device_ready !== 1'h1; i++)
			@(posedge ref_clk);
		check("ready", device_ready, 1);
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic t_start;
		tick(10);
		put_cmd(`RCS_CMD_SEND);
		tick(140);
		check("ready early", device_ready, 0);
		check("code while not ready", cmd_code, 0);
		wait_ready;
	endtask

	task automatic t_key;
		fill(8'hA0, 3);
		put_cmd(`RCS_CMD_KEYF);
		wait_idle;
		check("abort", n_abort, 1);
		check("no flush", fifo_count, 3);
		fill(8'hA3, 3);
		put_cmd(`RCS_CMD_KEYF);
		wait_idle;
		check("fifo drained", fifo_count, 0);
		check("key count", keyq.size(), 6);
		foreach (keyq[i])
			check("key", keyq[i], {3'(i), 8'hA0 + 8'(i)});
	endtask

	task automatic t_tx;
		fill(8'h5A, 2);
		put_cmd(`RCS_CMD_SEND);
		wait_idle;
		check("symbols", txq.size(), 4);
		check("start", txq[0][9:8], 1);
		check("data0", txq[1], {2'h0, 8'h5A});
		check("data1", txq[2], {2'h0, 8'h5B});
		check("end", txq[3][9:8], 2);
		tx_frame_config <= 2'h0;
		fill(8'h11, 1);
		put_cmd(`RCS_CMD_XCV);
		for (int i = 0; i < 100 && rx_enable !== 1'h1; i++)
			@(posedge ref_clk);
		check("receive on", rx_enable, 1);
		check("code receive", cmd_code, `RCS_CMD_RECV);
		put_cmd(`RCS_CMD_IDLE);
		tick(3);
		check("receive cut", rx_enable, 0);
		check("idle", cmd_code, 0);
		check("plain frame", txq.size(), 5);
		check("plain data", txq[4], {2'h0, 8'h11});
	endtask

	task automatic t_auth;
		fill(8'h60, 6);
		put_cmd(`RCS_CMD_AUTH);
		for (int i = 0; i < 40 && auth_start !== 1'h1; i++)
			@(posedge ref_clk);
		check("auth start", auth_start, 1);
		check("auth serial", auth_serial, 32'h65646362);
		check("auth block", {auth_key_b, auth_block}, 9'h061);
		auth_done <= 1'h1;
		tick(1);
		auth_done <= 1'h0;
		wait_idle;
	endtask

	task automatic t_nvm;
		put_cmd(`RCS_CMD_NWB);
		tick(10);
		check("args wait", cmd_code, `RCS_CMD_NWB);
		fill(8'h0C, 3);
		wait_idle;
		fill(8'h0C, 2);
		fill(8'h01, 1);
		put_cmd(`RCS_CMD_NRD);
		wait_idle;
		check("read count", fifo_count, 1);
		check("read byte", fifo_rd_data, 8'h0E);
		put_cmd(`RCS_CMD_RNG);
		tick(1100);
		check("random full", fifo_count, 10'h200);
		wait_idle;
	endtask

	task automatic t_detect;
		standby_sel <= 1'h1;
		put_cmd(`RCS_CMD_DETECT);
		tick(3);
		iq_valid <= 1'h1;
		tick(1);
		iq_valid <= 1'h0;
		wait_idle;
		check("detect irq", n_irq, 1);
		check("i result", i_result, 8'h30);
		check("q result", q_result, 8'h18);
		check("standby", standby_req, 1);
	endtask

	task automatic t_down;
		power_down_pin <= 1'h1;
		tick(60);
		power_down_pin <= 1'h0;
		tick(5);
		check("short high", device_ready, 1);
		power_down_pin <= 1'h1;
		tick(120);
		check("powered down", device_ready, 0);
		power_down_pin <= 1'h0;
		wait_ready;
		put_cmd(`RCS_CMD_SRST);
		tick(3);
		check("soft reset", device_ready, 0);
		wait_ready;
	endtask

	initial
	begin
		tick(3);
		reset <= 1'h0;
		t_start;
		t_key;
		t_tx;
		t_auth;
		t_nvm;
		t_detect;
		t_down;
		conclude();
	end
endmodule
